// File: inc/uepc_defs.svh
`ifndef UEPC_DEFS_SVH
`define UEPC_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UEPC_OFF_IRQ_EN 8'hC2
`define UEPC_OFF_EP_SEL 8'hC7
`define UEPC_OFF_EP_STAT 8'hCE
`define UEPC_OFF_FIFO_RST 8'hD5
`define UEPC_OFF_IRQ_SUM 8'hF8

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define UEPC_NUM_EP 7
`define UEPC_NUM_SRC 5
`define UEPC_SEL_W 3
`define UEPC_RSVD_BIT 7
`define UEPC_BYTE_ZERO 8'h00
`define UEPC_EP_ZERO 7'h00
`define UEPC_SEL_ZERO 3'h0
`define UEPC_SRC_ZERO 5'h00
`define UEPC_SRC_ONES 5'h1F
`define UEPC_SRC_SETUP_ONLY 5'h04

// ----------------------------------------
// Status source index inside the bank
// ----------------------------------------
`define UEPC_SRC_IN 0
`define UEPC_SRC_OUTB0 1
`define UEPC_SRC_SETUP 2
`define UEPC_SRC_STALL 3
`define UEPC_SRC_OUTB1 4

// ----------------------------------------
// Bit positions in the selected status byte
// ----------------------------------------
`define UEPC_STB_IN 0
`define UEPC_STB_OUTB0 1
`define UEPC_STB_SETUP 2
`define UEPC_STB_STALL 3
`define UEPC_STB_OUTB1 6

`endif

// File: inc/uepc_pkg.sv
package uepc_pkg;

  // ----------------------------------------
  // Shared types
  // ----------------------------------------
  typedef logic [7:0] uepc_byte_t;
  typedef logic [6:0] uepc_epvec_t;
  typedef logic [4:0] uepc_src_t;

endpackage

// File: verilog/uepc_status.sv
`timescale 1ns/1ps
`include "uepc_defs.svh"

module uepc_status #(
  parameter int NUM_EP = `UEPC_NUM_EP
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_EP-1:0] evt_in_done,
  input wire logic [NUM_EP-1:0] evt_out_b0,
  input wire logic [NUM_EP-1:0] evt_out_b1,
  input wire logic [NUM_EP-1:0] evt_setup,
  input wire logic [NUM_EP-1:0] evt_stall_crc,
  input wire logic clr_en,
  input wire logic [`UEPC_SEL_W-1:0] clr_ep,
  input wire uepc_pkg::uepc_src_t clr_keep,
  output logic [NUM_EP*`UEPC_NUM_SRC-1:0] stat_flat,
  output logic [NUM_EP-1:0] src_any
);

  // ----------------------------------------
  // Status bank
  // ----------------------------------------
  uepc_pkg::uepc_src_t stat_q [NUM_EP];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int e = 0; e < NUM_EP; e++)
        stat_q[e] <= `UEPC_SRC_ZERO;
    end
    else
    begin
      for (int e = 0; e < NUM_EP; e++)
      begin
        if (evt_setup[e])
          stat_q[e] <= `UEPC_SRC_SETUP_ONLY;
        else
        begin
          // Set beats a clear in the same cycle
          stat_q[e] <= (stat_q[e] & ((clr_en && clr_ep == e[`UEPC_SEL_W-1:0]) ?
            clr_keep : `UEPC_SRC_ONES)) |
            {evt_out_b1[e], evt_stall_crc[e], 1'b0, evt_out_b0[e], evt_in_done[e]};
        end
      end
    end
  end

  always_comb
  begin
    for (int e = 0; e < NUM_EP; e++)
    begin
      stat_flat[e*`UEPC_NUM_SRC +: `UEPC_NUM_SRC] = stat_q[e];
      src_any[e] = |stat_q[e];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  generate
    for (genvar g = 0; g < NUM_EP; g++)
    begin : g_chk
      a_setup_wipes: assert property (@(posedge clk) disable iff (rst)
        evt_setup[g] |=> stat_q[g] == `UEPC_SRC_SETUP_ONLY)
        else $error("Setup did not leave only the setup bit");
    end
  endgenerate

endmodule // uepc_status

// File: verilog/uepc_top.sv
// Notes on behaviour
// - Top bit of FIFO reset and summary registers always reads zero.
// - One FIFO reset bit per endpoint 0..6; set holds that FIFO in reset.
// - Clearing the bit releases the FIFO; only then may it be used.
// - Read-only summary register at F8h; bit n flags endpoint n.
// - A flag sets whenever any condition is present on its endpoint.
// - Conditions: IN done, OUT bank 0, OUT bank 1, SETUP, stall or CRC.
// - The interrupt comes from a flag only when its enable bit is set.
// - Flag clears itself once all sources clear; firmware cannot clear it.
// - Enable register: one bit per endpoint at the flag's position.
// - SETUP received sets its source and clears the other sources.
`timescale 1ns/1ps
`include "uepc_defs.svh"

module uepc_top #(
  parameter int NUM_EP = `UEPC_NUM_EP
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic [NUM_EP-1:0] EVT_IN_DONE,
  input wire logic [NUM_EP-1:0] EVT_OUT_B0,
  input wire logic [NUM_EP-1:0] EVT_OUT_B1,
  input wire logic [NUM_EP-1:0] EVT_SETUP,
  input wire logic [NUM_EP-1:0] EVT_STALL_CRC,
  output logic [NUM_EP-1:0] FIFO_RESET,
  output logic USB_IRQ
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
    addr_hit = (addr == off);
  endfunction

  function automatic uepc_pkg::uepc_byte_t stat_byte(input uepc_pkg::uepc_src_t s);
    uepc_pkg::uepc_byte_t b;
    b = `UEPC_BYTE_ZERO;
    b[`UEPC_STB_IN] = s[`UEPC_SRC_IN];
    b[`UEPC_STB_OUTB0] = s[`UEPC_SRC_OUTB0];
    b[`UEPC_STB_SETUP] = s[`UEPC_SRC_SETUP];
    b[`UEPC_STB_STALL] = s[`UEPC_SRC_STALL];
    b[`UEPC_STB_OUTB1] = s[`UEPC_SRC_OUTB1];
    stat_byte = b;
  endfunction

  logic wr_fifo_rst;
  logic wr_irq_en;
  logic wr_ep_sel;
  logic wr_ep_stat;

  assign wr_fifo_rst = REG_WR && addr_hit(REG_ADDR, `UEPC_OFF_FIFO_RST);
  assign wr_irq_en = REG_WR && addr_hit(REG_ADDR, `UEPC_OFF_IRQ_EN);
  assign wr_ep_sel = REG_WR && addr_hit(REG_ADDR, `UEPC_OFF_EP_SEL);
  assign wr_ep_stat = REG_WR && addr_hit(REG_ADDR, `UEPC_OFF_EP_STAT);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [NUM_EP-1:0] fifo_rst_q;
  logic [NUM_EP-1:0] irq_en_q;
  logic [`UEPC_SEL_W-1:0] ep_sel_q;

  // Firmware owns these bits; hardware never sets them on its own
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      fifo_rst_q <= `UEPC_EP_ZERO;
    else if (wr_fifo_rst)
      fifo_rst_q <= REG_WDATA[NUM_EP-1:0];
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      irq_en_q <= `UEPC_EP_ZERO;
    else if (wr_irq_en)
      irq_en_q <= REG_WDATA[NUM_EP-1:0];
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      ep_sel_q <= `UEPC_SEL_ZERO;
    else if (wr_ep_sel)
      ep_sel_q <= REG_WDATA[`UEPC_SEL_W-1:0];
  end

  // ----------------------------------------
  // Status sources
  // ----------------------------------------
  logic [NUM_EP*`UEPC_NUM_SRC-1:0] stat_flat;
  logic [NUM_EP-1:0] src_any;
  uepc_pkg::uepc_src_t clr_keep;

  // Writing zero to a status bit clears it; writing one keeps it
  assign clr_keep = {REG_WDATA[`UEPC_STB_OUTB1], REG_WDATA[`UEPC_STB_STALL],
    REG_WDATA[`UEPC_STB_SETUP], REG_WDATA[`UEPC_STB_OUTB0], REG_WDATA[`UEPC_STB_IN]};

  uepc_status #(
    .NUM_EP(NUM_EP)
  ) u_status (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .evt_in_done(EVT_IN_DONE),
    .evt_out_b0(EVT_OUT_B0),
    .evt_out_b1(EVT_OUT_B1),
    .evt_setup(EVT_SETUP),
    .evt_stall_crc(EVT_STALL_CRC),
    .clr_en(wr_ep_stat),
    .clr_ep(ep_sel_q),
    .clr_keep(clr_keep),
    .stat_flat(stat_flat),
    .src_any(src_any)
  );

  uepc_pkg::uepc_src_t sel_stat;

  // Out-of-range selection reads as an empty endpoint
  always_comb
  begin
    sel_stat = `UEPC_SRC_ZERO;
    for (int e = 0; e < NUM_EP; e++)
    begin
      if (ep_sel_q == e[`UEPC_SEL_W-1:0])
        sel_stat = stat_flat[e*`UEPC_NUM_SRC +: `UEPC_NUM_SRC];
    end
  end

  // ----------------------------------------
  // Flags and interrupt
  // ----------------------------------------
  logic [NUM_EP-1:0] flag_q;
  logic irq_q;
  logic [NUM_EP-1:0] gated;

  assign gated = src_any & irq_en_q;

  // No write path: the flag follows its sources only
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      flag_q <= `UEPC_EP_ZERO;
    else
      flag_q <= src_any;
  end

  // Same timing as the flag so the two never disagree
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      irq_q <= 1'b0;
    else
      irq_q <= |gated;
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] rdata_q;

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rdata_q <= `UEPC_BYTE_ZERO;
    else if (REG_RD)
    begin
      rdata_q <= `UEPC_BYTE_ZERO;
      if (addr_hit(REG_ADDR, `UEPC_OFF_FIFO_RST))
        rdata_q[NUM_EP-1:0] <= fifo_rst_q;
      else if (addr_hit(REG_ADDR, `UEPC_OFF_IRQ_SUM))
        rdata_q[NUM_EP-1:0] <= flag_q;
      else if (addr_hit(REG_ADDR, `UEPC_OFF_IRQ_EN))
        rdata_q[NUM_EP-1:0] <= irq_en_q;
      else if (addr_hit(REG_ADDR, `UEPC_OFF_EP_SEL))
        rdata_q[`UEPC_SEL_W-1:0] <= ep_sel_q;
      else if (addr_hit(REG_ADDR, `UEPC_OFF_EP_STAT))
        rdata_q <= stat_byte(sel_stat);
    end
    else
      rdata_q <= `UEPC_BYTE_ZERO;
  end

  assign REG_RDATA = rdata_q;
  assign FIFO_RESET = fifo_rst_q;
  assign USB_IRQ = irq_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_rd_sum;
    REG_RD && REG_ADDR == `UEPC_OFF_IRQ_SUM;
  endsequence

  sequence s_wr_fifo;
    REG_WR && REG_ADDR == `UEPC_OFF_FIFO_RST;
  endsequence

  sequence s_wr_en;
    REG_WR && REG_ADDR == `UEPC_OFF_IRQ_EN;
  endsequence

  a_rsvd_reads_zero: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (REG_RD && (REG_ADDR == `UEPC_OFF_IRQ_SUM || REG_ADDR == `UEPC_OFF_FIFO_RST))
      |=> REG_RDATA[`UEPC_RSVD_BIT] == 1'b0)
    else $error("Reserved bit read as one");

  a_fifo_hold: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    s_wr_fifo ##1 (!REG_WR)[*2] |-> FIFO_RESET == $past(REG_WDATA[NUM_EP-1:0], 2))
    else $error("FIFO reset output lost the written value");

  a_summary_read: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    s_rd_sum |=> REG_RDATA == {1'b0, $past(flag_q)})
    else $error("Summary read does not match flags");

  a_flag_sets: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (|src_any) |=> (flag_q & $past(src_any)) == $past(src_any))
    else $error("Flag missed a pending source");

  a_flag_self_clear: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (src_any == `UEPC_EP_ZERO) ##1 (src_any == `UEPC_EP_ZERO) |-> flag_q == `UEPC_EP_ZERO)
    else $error("Flag stayed set with no source");

  a_irq_gating: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ##1 USB_IRQ == (|$past(gated)))
    else $error("Interrupt does not follow flag and enable");

  a_enable_write: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    s_wr_en |=> irq_en_q == $past(REG_WDATA[NUM_EP-1:0]))
    else $error("Enable register did not take the write");

  a_setup_irq: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ((|(EVT_SETUP & irq_en_q)) && !wr_irq_en) |=> ##1 USB_IRQ)
    else $error("Setup on an enabled endpoint raised no interrupt");

endmodule // uepc_top

// File: verification/uepc_usb_model.sv
`timescale 1ns/1ps

module uepc_usb_model #(
  parameter int NUM_EP = 7
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_EP-1:0] fifo_reset,
  input wire logic go,
  input wire logic [2:0] ep,
  input wire logic [2:0] kind,
  output logic [NUM_EP-1:0] in_done,
  output logic [NUM_EP-1:0] out_b0,
  output logic [NUM_EP-1:0] out_b1,
  output logic [NUM_EP-1:0] setup,
  output logic [NUM_EP-1:0] stall_crc
);
  // ----------------------------------------
  // Event pulses, one cycle each
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    in_done <= '0;
    out_b0 <= '0;
    out_b1 <= '0;
    setup <= '0;
    stall_crc <= '0;
    // Held FIFOs stay silent
    if (!rst && go && !fifo_reset[ep])
    begin
      case (kind)
        3'h0: in_done[ep] <= 1'b1;
        3'h1: out_b0[ep] <= 1'b1;
        3'h2: out_b1[ep] <= 1'b1;
        3'h3: setup[ep] <= 1'b1;
        default: stall_crc[ep] <= 1'b1;
      endcase
    end
  end
endmodule // uepc_usb_model

// File: verification/uepc_top_tb.sv
`timescale 1ns/1ps
`include "uepc_defs.svh"

module uepc_top_tb;
  typedef struct {logic [2:0] ep; logic [2:0] kind; logic [7:0] en; logic [7:0] st; logic irq;} uepc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic go = 1'b0;
  logic [2:0] ep = 3'h0;
  logic [2:0] kind = 3'h0;
  uepc_pkg::uepc_byte_t rdata;
  logic [6:0] e0, e1, e2, e3, e4, fifo_rst;
  logic irq;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  uepc_row_t rows [7] = '{'{3'h0, 3'h0, 8'h7F, 8'h01, 1'b1}, '{3'h1, 3'h1, 8'h00, 8'h02, 1'b0},
    '{3'h2, 3'h2, 8'h04, 8'h40, 1'b1}, '{3'h3, 3'h3, 8'h7F, 8'h04, 1'b1},
    '{3'h4, 3'h4, 8'h6F, 8'h08, 1'b0}, '{3'h5, 3'h0, 8'h20, 8'h01, 1'b1},
    '{3'h6, 3'h1, 8'h40, 8'h02, 1'b1}};

  always #50 clk = ~clk;

  uepc_top uepc_top_i (.CORE_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .EVT_IN_DONE(e0), .EVT_OUT_B0(e1),
    .EVT_OUT_B1(e2), .EVT_SETUP(e3), .EVT_STALL_CRC(e4), .FIFO_RESET(fifo_rst), .USB_IRQ(irq));

  uepc_usb_model uepc_usb_model_i (.clk(clk), .rst(rst), .fifo_reset(fifo_rst), .go(go),
    .ep(ep), .kind(kind), .in_done(e0), .out_b0(e1), .out_b1(e2), .setup(e3), .stall_crc(e4));

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Top bit always written as zero
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d & 8'h7F;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task fire(input logic [2:0] p, input logic [2:0] k);
    @(posedge clk);
    ep <= p;
    kind <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task give_verdict;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Bounds a hang; the whole run needs well under this
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rst <= 1'b0;
    rdc(`UEPC_OFF_IRQ_SUM, 8'h00);
    rdc(`UEPC_OFF_FIFO_RST, 8'h00);
    rdc(`UEPC_OFF_IRQ_EN, 8'h00);
    wr(`UEPC_OFF_FIFO_RST, 8'hFF);
    #1 chk({1'b0, fifo_rst}, 8'h7F);
    rdc(`UEPC_OFF_FIFO_RST, 8'h7F);
    wr(`UEPC_OFF_FIFO_RST, 8'h00);
    #1 chk({1'b0, fifo_rst}, 8'h00);
    $display("Test reset and fifo done");
    foreach (rows[i])
    begin
      wr(`UEPC_OFF_IRQ_EN, rows[i].en);
      fire(rows[i].ep, rows[i].kind);
      @(posedge clk);
      #1 chk({7'h00, irq}, 8'h00);
      @(posedge clk);
      #1 chk({7'h00, irq}, {7'h00, rows[i].irq});
      rdc(`UEPC_OFF_IRQ_SUM, 8'h01 << rows[i].ep);
      wr(`UEPC_OFF_EP_SEL, {5'h00, rows[i].ep});
      rdc(`UEPC_OFF_EP_STAT, rows[i].st);
      wr(`UEPC_OFF_EP_STAT, 8'h00);
      rdc(`UEPC_OFF_IRQ_SUM, 8'h00);
      chk({7'h00, irq}, 8'h00);
    end
    $display("Test table done");
    wr(`UEPC_OFF_IRQ_EN, 8'h02);
    fire(3'h1, 3'h0);
    fire(3'h1, 3'h1);
    fire(3'h1, 3'h3);
    wr(`UEPC_OFF_IRQ_SUM, 8'h00);
    rdc(`UEPC_OFF_IRQ_SUM, 8'h02);
    wr(`UEPC_OFF_EP_SEL, 8'h01);
    rdc(`UEPC_OFF_EP_STAT, 8'h04);
    rdc(8'h10, 8'h00);
    wr(`UEPC_OFF_EP_SEL, 8'h07);
    rdc(`UEPC_OFF_EP_STAT, 8'h00);
    chk({7'h00, irq}, 8'h01);
    wr(`UEPC_OFF_IRQ_EN, 8'h00);
    @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00);
    rdc(`UEPC_OFF_IRQ_SUM, 8'h02);
    $display("Test awkward cases done");
    // Bus reset seen: firmware holds every FIFO again
    wr(`UEPC_OFF_FIFO_RST, 8'h7F);
    #1 chk({1'b0, fifo_rst}, 8'h7F);
    wr(`UEPC_OFF_IRQ_EN, 8'h02);
    @(posedge clk);
    #1 chk({7'h00, irq}, 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1 chk({1'b0, fifo_rst}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    rdc(`UEPC_OFF_IRQ_SUM, 8'h00);
    rdc(`UEPC_OFF_IRQ_EN, 8'h00);
    $display("Test mid-run reset done");
    give_verdict();
  end
endmodule // uepc_top_tb
